//--- rls_pkg.sv
// Constants for the return link signalling framer: register map,
// field positions, frame kinds and fixed frame figures.
// Assumes a byte-wide output stream and a 32-bit register port.
package rls_pkg;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CMD      = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_ROUTE    = 8'h0C;
  localparam logic [7:0] REG_REQUEST  = 8'h10;
  localparam logic [7:0] REG_GROUP    = 8'h14;
  localparam logic [7:0] REG_COMP     = 8'h18;
  localparam logic [7:0] REG_TS       = 8'h1C;
  localparam logic [7:0] REG_LABEL    = 8'h20;
  localparam logic [7:0] REG_MSG_LEN  = 8'h24;
  localparam logic [7:0] REG_MEM_ADDR = 8'h28;
  localparam logic [7:0] REG_MEM_DATA = 8'h2C;

  // Control register bits
  localparam int CTRL_PREFIX_EN  = 0;
  localparam int CTRL_AF_EN      = 1;
  localparam int CTRL_LABEL_EN   = 2;
  localparam int CTRL_AF_PAYLOAD = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Status register bits
  localparam int STAT_BUSY    = 0;
  localparam int STAT_ERROR   = 1;
  localparam int STAT_REFUSED = 2;

  // Composition register fields
  localparam int COMP_ROUTE = 0;
  localparam int COMP_ACM   = 1;
  localparam int COMP_MOB   = 2;
  localparam int COMP_REQ   = 3;
  localparam int COMP_MC    = 4;
  localparam int COMP_GROUP = 5;
  localparam int COMP_LOGON = 6;
  localparam int COMP_CNT_LO = 7;
  localparam int COMP_LEN_LO = 10;

  // Frame kinds written to the command register
  localparam logic [2:0] KIND_PREFIX  = 3'h0;
  localparam logic [2:0] KIND_SYNC    = 3'h1;
  localparam logic [2:0] KIND_CONTEND = 3'h2;
  localparam logic [2:0] KIND_AF      = 3'h3;
  localparam logic [2:0] KIND_LABEL   = 3'h4;

  // Short frame lengths in bytes
  localparam logic [9:0] PREFIX_LEN  = 10'h004;
  localparam logic [9:0] SYNC_LEN    = 10'h002;
  localparam logic [9:0] CONTEND_LEN = 10'h005;
  localparam logic [9:0] AF_HDR_LEN  = 10'h009;

  // Transport packet figures
  localparam logic [7:0] TS_SYNC_BYTE  = 8'h47;
  localparam logic [7:0] AF_FLAGS_BYTE = 8'h02;
  localparam logic [7:0] AF_FIXED_LEN  = 8'h02;
  localparam logic [7:0] COMP_HDR_LEN  = 8'h02;
  localparam logic [1:0] AFC_ONLY      = 2'h2;
  localparam logic [1:0] AFC_PAYLOAD   = 2'h3;

  // Labelling message and cell figures
  localparam logic [7:0] ELEM_MAX       = 8'h40;
  localparam logic [5:0] CELL_HDR_LEN   = 6'h05;
  localparam logic [5:0] CELL_LAST_BYTE = 6'h34;
  localparam logic [5:0] TRAILER_START  = 6'h28;
  localparam logic [5:0] CRC_START      = 6'h2C;
  localparam logic [9:0] CELL_PAYLOAD   = 10'h030;
  localparam logic [9:0] TRAILER_LEN    = 10'h008;
  localparam logic [7:0] HEC_COSET      = 8'h55;
  localparam logic [7:0] CRC8_POLY      = 8'h07;
  localparam logic [31:0] CRC32_POLY    = 32'h04C11DB7;
  localparam logic [31:0] CRC32_INIT    = 32'hFFFFFFFF;
  localparam int MEM_DEPTH = 256;

endpackage

//--- rls_framer.sv
// Return link signalling framer: builds prefix, mini-slot, contention,
// adaptation-field and labelling-cell byte streams from registers.
// Assumes one 25 MHz clock, a plain register port and a downstream
// byte sink that may stall through out_ready.
//
// Behaviour
// - Prefix enabled: route and request before bursts
// - Mini-slot frame carries request sub-field
// - Contention frame adds group and logon identifiers
// - Adaptation-field carrier switchable by configuration
// - Start indicator set only when payload follows
// - Return-link packet identifier, priority bit zero
// - Field control 10 alone, 11 with payload
// - Field length two plus private length
// - All adaptation flags zero except private data
// - Composition header precedes signalling field
// - Composition fields mirror broadcast table meaning
// - Labelling mode sends messages in granted units
// - Either side may open the message channel
// - Channel cells carry header, payload-type MSB one
// - Message holds 1 to 64 elements
// - Element: type, length byte, non-empty body
// - Message segmented with AAL5 trailer and CRC
`timescale 1ns/100ps
`default_nettype none
module rls_framer
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  // Byte stream towards the burst path
  output var  logic [7:0]  out_data,
  output var  logic        out_valid,
  output var  logic        out_last,
  input  wire logic        out_ready,
  // Status
  output var  logic        busy
);
  import rls_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_SHORT, ST_CELL} rls_state_e;

  function automatic logic [31:0] crc32_byte(input logic [31:0] crc,
                                             input logic [7:0]  b);
    logic [31:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--)
    begin
      if (c[31] ^ b[i])
        c = {c[30:0], 1'b0} ^ CRC32_POLY;
      else
        c = {c[30:0], 1'b0};
    end
    return c;
  endfunction

  function automatic logic [7:0] hec(input logic [31:0] hdr);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--)
    begin
      if (c[7] ^ hdr[i])
        c = {c[6:0], 1'b0} ^ CRC8_POLY;
      else
        c = {c[6:0], 1'b0};
    end
    return c ^ HEC_COSET;
  endfunction

  // Configuration
  logic [3:0]  ctrl_ff;
  logic [15:0] route_ff;
  logic [15:0] request_ff;
  logic [7:0]  group_ff;
  logic [15:0] logon_ff;
  logic [14:0] comp_ff;
  logic [12:0] pid_ff;
  logic [3:0]  cc_ff;
  logic [27:0] label_ff;
  logic [8:0]  msg_len_ff;
  logic [7:0]  mem_addr_ff;
  logic [7:0]  mem [MEM_DEPTH];
  // Sequencer
  rls_state_e  state_ff;
  logic [2:0]  kind_ff;
  logic [9:0]  idx_ff;
  logic [9:0]  frame_len_ff;
  logic [9:0]  pdu_idx_ff;
  logic [5:0]  cell_byte_ff;
  logic        last_cell_ff;
  logic [31:0] crc_ff;
  logic [8:0]  elem_ptr_ff;
  logic [7:0]  elem_cnt_ff;
  logic        error_ff;
  logic        refused_ff;
  // Two-entry output buffer: head is the output, skid catches a stall
  logic [7:0]  skid_data_ff;
  logic        skid_last_ff;
  logic        skid_valid_ff;

  logic        cmd_wr;
  logic        cmd_ok;
  logic [2:0]  cmd_kind;
  logic        gen_ready;
  logic        gen_push;
  logic [7:0]  gen_byte;
  logic        gen_last;
  logic [4:0]  sig_len;
  logic [7:0]  priv_len;
  logic        af_payload;
  logic [5:0]  body_off;
  logic [5:0]  trailer_off;
  logic        last_now;
  logic [31:0] cell_hdr;
  logic [15:0] pdu_len16;
  logic [31:0] crc_out;
  logic [9:0]  elem_next;

  assign cmd_wr     = reg_wr && (reg_addr == REG_CMD);
  assign cmd_kind   = reg_wdata[2:0];
  assign sig_len    = comp_ff[COMP_LEN_LO +: 5];
  assign priv_len   = COMP_HDR_LEN + {3'b000, sig_len};
  assign af_payload = ctrl_ff[CTRL_AF_PAYLOAD];
  assign gen_ready  = !skid_valid_ff;
  assign body_off   = cell_byte_ff - CELL_HDR_LEN;
  assign trailer_off = body_off - TRAILER_START;
  assign pdu_len16  = {7'h00, msg_len_ff};
  assign crc_out    = ~crc_ff;
  assign elem_next  = {1'b0, elem_ptr_ff} + 10'h002
                      + {2'b00, mem[elem_ptr_ff[7:0] + 8'h01]};
  // Last cell once the message and trailer fit in this cell
  assign last_now   = (pdu_idx_ff + CELL_PAYLOAD)
                      >= ({1'b0, msg_len_ff} + TRAILER_LEN);
  // Payload type: MSB one marks the channel, LSB ends the message
  assign cell_hdr   = {label_ff, 1'b1, 1'b0, last_now, 1'b0};

  // Disabled carriers and commands while busy are refused
  always_comb
  begin
    case (cmd_kind)
      KIND_PREFIX:  cmd_ok = ctrl_ff[CTRL_PREFIX_EN];
      KIND_SYNC:    cmd_ok = 1'b1;
      KIND_CONTEND: cmd_ok = 1'b1;
      KIND_AF:      cmd_ok = ctrl_ff[CTRL_AF_EN];
      KIND_LABEL:   cmd_ok = ctrl_ff[CTRL_LABEL_EN];
      default:      cmd_ok = 1'b0;
    endcase
    if (state_ff != ST_IDLE)
      cmd_ok = 1'b0;
  end

  // Byte generator, all fields MSB first
  always_comb
  begin
    gen_byte = 8'h00;
    gen_last = 1'b0;
    if (state_ff == ST_SHORT)
    begin
      gen_last = (idx_ff == frame_len_ff - 10'h001);
      case (kind_ff)
        KIND_PREFIX:
        begin
          case (idx_ff[1:0])
            2'h0:    gen_byte = route_ff[15:8];
            2'h1:    gen_byte = route_ff[7:0];
            2'h2:    gen_byte = request_ff[15:8];
            default: gen_byte = request_ff[7:0];
          endcase
        end
        KIND_SYNC:
          gen_byte = idx_ff[0] ? request_ff[7:0] : request_ff[15:8];
        KIND_CONTEND:
        begin
          case (idx_ff[2:0])
            3'h0:    gen_byte = request_ff[15:8];
            3'h1:    gen_byte = request_ff[7:0];
            3'h2:    gen_byte = group_ff;
            3'h3:    gen_byte = logon_ff[15:8];
            default: gen_byte = logon_ff[7:0];
          endcase
        end
        default:
        begin
          case (idx_ff)
            10'h000: gen_byte = TS_SYNC_BYTE;
            // Error bit zero, start flag, priority zero
            10'h001: gen_byte = {1'b0, af_payload, 1'b0, pid_ff[12:8]};
            10'h002: gen_byte = pid_ff[7:0];
            10'h003: gen_byte = {2'b00,
                                 af_payload ? AFC_PAYLOAD : AFC_ONLY,
                                 cc_ff};
            10'h004: gen_byte = AF_FIXED_LEN + priv_len;
            10'h005: gen_byte = AF_FLAGS_BYTE;
            10'h006: gen_byte = priv_len;
            // Composition header mirrors table fields
            10'h007: gen_byte = {comp_ff[COMP_ROUTE], comp_ff[COMP_ACM],
                                 comp_ff[COMP_MOB], sig_len};
            10'h008: gen_byte = {comp_ff[COMP_REQ], comp_ff[COMP_MC],
                                 comp_ff[COMP_GROUP], comp_ff[COMP_LOGON],
                                 comp_ff[COMP_CNT_LO +: 3], 1'b0};
            default: gen_byte = mem[8'(idx_ff - AF_HDR_LEN)];
          endcase
        end
      endcase
    end
    else if (state_ff == ST_CELL)
    begin
      if (cell_byte_ff < CELL_HDR_LEN)
      begin
        case (cell_byte_ff[2:0])
          3'h0:    gen_byte = cell_hdr[31:24];
          3'h1:    gen_byte = cell_hdr[23:16];
          3'h2:    gen_byte = cell_hdr[15:8];
          3'h3:    gen_byte = cell_hdr[7:0];
          default: gen_byte = hec(cell_hdr);
        endcase
      end
      else if (last_cell_ff && body_off >= TRAILER_START)
      begin
        gen_last = (cell_byte_ff == CELL_LAST_BYTE);
        case (trailer_off[2:0])
          3'h2:    gen_byte = pdu_len16[15:8];
          3'h3:    gen_byte = pdu_len16[7:0];
          3'h4:    gen_byte = crc_out[31:24];
          3'h5:    gen_byte = crc_out[23:16];
          3'h6:    gen_byte = crc_out[15:8];
          3'h7:    gen_byte = crc_out[7:0];
          default: gen_byte = 8'h00;
        endcase
      end
      else if (pdu_idx_ff < {1'b0, msg_len_ff})
        gen_byte = mem[pdu_idx_ff[7:0]];
      else
        gen_byte = 8'h00;
    end
  end

  assign gen_push = gen_ready
                    && (state_ff == ST_SHORT || state_ff == ST_CELL);

  // Register writes
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl_ff     <= CTRL_RESET;
      route_ff    <= 16'h0000;
      request_ff  <= 16'h0000;
      group_ff    <= 8'h00;
      logon_ff    <= 16'h0000;
      comp_ff     <= 15'h0000;
      pid_ff      <= 13'h0000;
      label_ff    <= 28'h0000000;
      msg_len_ff  <= 9'h000;
      mem_addr_ff <= 8'h00;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        REG_CTRL:     ctrl_ff     <= reg_wdata[3:0];
        REG_ROUTE:    route_ff    <= reg_wdata[15:0];
        REG_REQUEST:  request_ff  <= reg_wdata[15:0];
        REG_GROUP:
        begin
          group_ff <= reg_wdata[7:0];
          logon_ff <= reg_wdata[23:8];
        end
        REG_COMP:     comp_ff     <= reg_wdata[14:0];
        REG_TS:       pid_ff      <= reg_wdata[12:0];
        REG_LABEL:    label_ff    <= reg_wdata[31:4];
        REG_MSG_LEN:  msg_len_ff  <= reg_wdata[8:0];
        REG_MEM_ADDR: mem_addr_ff <= reg_wdata[7:0];
        REG_MEM_DATA: mem_addr_ff <= mem_addr_ff + 8'h01;
        default:      ctrl_ff     <= ctrl_ff;
      endcase
    end
  end

  // Message memory holds both signalling field and labelling message
  always_ff @(posedge sys_clk)
  begin
    if (reg_wr && reg_addr == REG_MEM_DATA)
      mem[mem_addr_ff] <= reg_wdata[7:0];
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:     reg_rdata <= {28'h0000000, ctrl_ff};
        REG_STATUS:   reg_rdata <= {29'h00000000, refused_ff, error_ff,
                                    state_ff != ST_IDLE};
        REG_ROUTE:    reg_rdata <= {16'h0000, route_ff};
        REG_REQUEST:  reg_rdata <= {16'h0000, request_ff};
        REG_GROUP:    reg_rdata <= {8'h00, logon_ff, group_ff};
        REG_COMP:     reg_rdata <= {17'h00000, comp_ff};
        REG_TS:       reg_rdata <= {15'h0000, cc_ff, pid_ff};
        REG_LABEL:    reg_rdata <= {label_ff, 4'h0};
        REG_MSG_LEN:  reg_rdata <= {23'h000000, msg_len_ff};
        REG_MEM_ADDR: reg_rdata <= {24'h000000, mem_addr_ff};
        REG_MEM_DATA: reg_rdata <= {24'h000000, mem[mem_addr_ff]};
        default:      reg_rdata <= 32'h00000000;
      endcase
    end
    else
      reg_rdata <= 32'h00000000;
  end

  // Command acceptance and status flags; a new accepted command clears
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      refused_ff <= 1'b0;
      kind_ff    <= KIND_PREFIX;
    end
    else if (cmd_wr)
    begin
      refused_ff <= !cmd_ok;
      if (cmd_ok)
        kind_ff <= cmd_kind;
    end
  end

  // Sequencer
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_ff     <= ST_IDLE;
      idx_ff       <= 10'h000;
      frame_len_ff <= 10'h000;
      elem_ptr_ff  <= 9'h000;
      elem_cnt_ff  <= 8'h00;
      error_ff     <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          idx_ff      <= 10'h000;
          elem_ptr_ff <= 9'h000;
          elem_cnt_ff <= 8'h00;
          if (cmd_wr && cmd_ok)
          begin
            error_ff <= 1'b0;
            case (cmd_kind)
              KIND_PREFIX:  frame_len_ff <= PREFIX_LEN;
              KIND_SYNC:    frame_len_ff <= SYNC_LEN;
              KIND_CONTEND: frame_len_ff <= CONTEND_LEN;
              default:      frame_len_ff <= AF_HDR_LEN + {5'h00, sig_len};
            endcase
            state_ff <= (cmd_kind == KIND_LABEL) ? ST_CHECK : ST_SHORT;
          end
        end
        // Walk element headers before anything is sent
        ST_CHECK:
        begin
          if (elem_ptr_ff == msg_len_ff)
          begin
            if (elem_cnt_ff == 8'h00 || elem_cnt_ff > ELEM_MAX)
            begin
              error_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end
            else
              state_ff <= ST_CELL;
          end
          else if ({1'b0, elem_ptr_ff} + 10'h002 > {1'b0, msg_len_ff}
                   || mem[elem_ptr_ff[7:0] + 8'h01] == 8'h00
                   || elem_next > {1'b0, msg_len_ff}
                   || elem_cnt_ff == ELEM_MAX)
          begin
            error_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
          else
          begin
            elem_ptr_ff <= elem_next[8:0];
            elem_cnt_ff <= elem_cnt_ff + 8'h01;
          end
        end
        ST_SHORT:
        begin
          if (gen_push)
          begin
            idx_ff <= idx_ff + 10'h001;
            if (gen_last)
              state_ff <= ST_IDLE;
          end
        end
        ST_CELL:
        begin
          if (gen_push && gen_last)
            state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Cell segmentation and running CRC over the whole message unit
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || state_ff == ST_IDLE)
    begin
      cell_byte_ff <= 6'h00;
      pdu_idx_ff   <= 10'h000;
      last_cell_ff <= 1'b0;
      crc_ff       <= CRC32_INIT;
    end
    else if (state_ff == ST_CELL && gen_push)
    begin
      cell_byte_ff <= (cell_byte_ff == CELL_LAST_BYTE) ? 6'h00
                      : cell_byte_ff + 6'h01;
      if (cell_byte_ff == CELL_HDR_LEN - 6'h01)
        last_cell_ff <= last_now;
      if (cell_byte_ff >= CELL_HDR_LEN)
      begin
        pdu_idx_ff <= pdu_idx_ff + 10'h001;
        // CRC covers all but its own four bytes
        if (!(last_cell_ff && body_off >= CRC_START))
          crc_ff <= crc32_byte(crc_ff, gen_byte);
      end
    end
  end

  // Continuity counter advances per adaptation-field packet
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      cc_ff <= 4'h0;
    else if (state_ff == ST_SHORT && kind_ff == KIND_AF
             && gen_push && gen_last)
      cc_ff <= cc_ff + 4'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      busy <= 1'b0;
    else
      busy <= (state_ff != ST_IDLE) || (cmd_wr && cmd_ok);
  end

  // Output buffer; skid only fills while the sink stalls
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      out_valid     <= 1'b0;
      out_data      <= 8'h00;
      out_last      <= 1'b0;
      skid_valid_ff <= 1'b0;
      skid_data_ff  <= 8'h00;
      skid_last_ff  <= 1'b0;
    end
    else if (!out_valid || out_ready)
    begin
      if (skid_valid_ff)
      begin
        out_valid     <= 1'b1;
        out_data      <= skid_data_ff;
        out_last      <= skid_last_ff;
        skid_valid_ff <= 1'b0;
      end
      else
      begin
        out_valid <= gen_push;
        out_data  <= gen_push ? gen_byte : 8'h00;
        out_last  <= gen_push && gen_last;
      end
    end
    else if (gen_push)
    begin
      skid_valid_ff <= 1'b1;
      skid_data_ff  <= gen_byte;
      skid_last_ff  <= gen_last;
    end
  end

endmodule
`default_nettype wire

//--- rls_framer_monitor.sv
// Checker for the framer: stream framing and field values.
// Assumes it is bound to rls_framer and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module rls_monitor
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // Stream and status
  input wire logic [7:0]  out_data,
  input wire logic        out_valid,
  input wire logic        out_last,
  input wire logic        out_ready,
  input wire logic        busy
);
  import rls_pkg::*;
  logic [2:0]  kind_ff;
  logic [15:0] idx_ff;
  logic        pay_ff;
  logic [7:0]  len4_ff;
  logic [7:0]  len6_ff;
  logic        cmd_go;
  logic        take;
  // Latch the kind only when idle, so old bytes are not misjudged
  assign cmd_go = reg_wr && reg_addr == REG_CMD && !busy && !out_valid;
  assign take   = out_valid && out_ready;
  always_ff @(posedge sys_clk)
    if (sys_rst)
      kind_ff <= 3'h7;
    else if (cmd_go)
      kind_ff <= reg_wdata[2:0];
  always_ff @(posedge sys_clk)
    if (sys_rst || cmd_go || (take && out_last))
      idx_ff <= 16'h0000;
    else if (take)
      idx_ff <= idx_ff + 16'h0001;
  always_ff @(posedge sys_clk)
    if (sys_rst)
      pay_ff <= 1'b0;
    else if (reg_wr && reg_addr == REG_CTRL)
      pay_ff <= reg_wdata[CTRL_AF_PAYLOAD];
  always_ff @(posedge sys_clk)
  begin
    if (take && idx_ff == 16'h0004)
      len4_ff <= out_data;
    if (take && idx_ff == 16'h0006)
      len6_ff <= out_data;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence af_at(int n);
    out_valid && kind_ff == KIND_AF && idx_ff == n;
  endsequence
  sequence sync_go;
    cmd_go && reg_wdata[2:0] == KIND_SYNC;
  endsequence
  sequence first_byte;
    busy ##1 out_valid;
  endsequence
  af_sync_a: assert property (af_at(0) |-> out_data == TS_SYNC_BYTE)
    else $error("af sync byte wrong");
  af_start_a: assert property (af_at(1) |->
    out_data[7:5] == {1'b0, pay_ff, 1'b0}) else $error("af start bit wrong");
  af_ctrl_a: assert property (af_at(3) |->
    out_data[7:4] == (pay_ff ? 4'h3 : 4'h2)) else $error("af control wrong");
  af_flags_a: assert property (af_at(5) |-> out_data == AF_FLAGS_BYTE)
    else $error("af flags wrong");
  af_len_a: assert property (af_at(6) |-> out_data + 8'h02 == len4_ff)
    else $error("af length wrong");
  comp_len_a: assert property (af_at(7) |->
    out_data[4:0] + 5'h02 == len6_ff[4:0]) else $error("comp length wrong");
  comp_rsv_a: assert property (af_at(8) |-> !out_data[0])
    else $error("reserved bit set");
  cell_pt_a: assert property (out_valid && kind_ff == KIND_LABEL &&
    idx_ff % 53 == 3 |-> out_data[3]) else $error("cell type bit clear");
  cell_end_a: assert property (out_valid && out_last &&
    kind_ff == KIND_LABEL |-> idx_ff % 53 == 52) else $error("cell end wrong");
  short_len_a: assert property (out_valid && out_last &&
    kind_ff <= KIND_CONTEND |-> idx_ff == (kind_ff == KIND_PREFIX ? 16'h3 :
    kind_ff == KIND_SYNC ? 16'h1 : 16'h4)) else $error("frame length wrong");
  sync_start_a: assert property (sync_go |=> first_byte)
    else $error("sync frame late");
  hold_stall_a: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data) && $stable(out_last))
    else $error("stalled byte changed");
endmodule
bind rls_framer rls_monitor u_rls_monitor (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .out_data(out_data), .out_valid(out_valid),
  .out_last(out_last), .out_ready(out_ready), .busy(busy));
`default_nettype wire

//--- rls_sink.sv
// Burst path model taking framer bytes into a queue.
// Assumes the bench reads and empties the queue between frames.
`timescale 1ns/100ps
`default_nettype none
module rls_sink
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Stream
  input  wire logic [7:0] out_data,
  input  wire logic       out_valid,
  input  wire logic       out_last,
  output var  logic       out_ready,
  // Pacing
  input  wire logic       slow
);
  logic [1:0] cnt_ff;
  logic [8:0] got[$];
  // One byte in three keeps the buffer full and stalls the source
  always_ff @(posedge sys_clk)
    if (sys_rst || cnt_ff == 2'h2)
      cnt_ff <= 2'h0;
    else
      cnt_ff <= cnt_ff + 2'h1;
  assign out_ready = !sys_rst && (!slow || cnt_ff == 2'h2);
  always @(posedge sys_clk)
    if (out_valid && out_ready)
      got.push_back({out_last, out_data});
endmodule
`default_nettype wire

//--- tb.sv
// Bench for the framer: register tasks, frame-by-frame compares.
// Assumes the framer, its package, the sink model and checker.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rls_pkg::*;
  logic        sys_clk;
  logic        sys_rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [7:0]  out_data;
  logic        out_valid;
  logic        out_last;
  logic        out_ready;
  logic        busy;
  logic        slow;
  int          err_total;
  int          checked;
  int          cycles;
  logic [8:0]  exp_q[$];
  rls_framer u_rls_framer (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_data(out_data),
    .out_valid(out_valid), .out_last(out_last),
    .out_ready(out_ready), .busy(busy));
  rls_sink u_rls_sink (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .out_data(out_data), .out_valid(out_valid), .out_last(out_last),
    .out_ready(out_ready), .slow(slow));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (e !== g)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
    @(posedge sys_clk);
  endtask
  // Bit 8 of an expected entry marks a byte left uncompared
  task automatic frame(input string nm);
    int n;
    n = 0;
    while (u_rls_sink.got.size() < exp_q.size() && n < 4000)
    begin
      @(posedge sys_clk);
      n++;
    end
    repeat (4) @(posedge sys_clk);
    chk({nm, " count"}, exp_q.size(), u_rls_sink.got.size());
    foreach (exp_q[i])
      if (i < u_rls_sink.got.size() && !exp_q[i][8])
        chk(nm, {i == exp_q.size() - 1, exp_q[i][7:0]}, u_rls_sink.got[i]);
    u_rls_sink.got.delete();
    exp_q.delete();
  endtask
  initial
  begin
    sys_rst   = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    slow      = 1'b0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(REG_CTRL, 32'h0, "ctrl reset");
    rd(8'hFC, 32'h0, "unmapped");
    wr(REG_ROUTE, 32'h0000A5C3);
    wr(REG_REQUEST, 32'h00001E2F);
    wr(REG_GROUP, 32'h003B4D6E);
    // Second command lands while busy and must be dropped
    reg_addr  <= REG_CMD;
    reg_wdata <= 32'h1;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wdata <= 32'h2;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    exp_q = {9'h01E, 9'h02F};
    frame("sync");
    rd(REG_STATUS, 32'h4, "busy refusal");
    slow <= 1'b1;
    wr(REG_CMD, 32'h2);
    exp_q = {9'h01E, 9'h02F, 9'h06E, 9'h03B, 9'h04D};
    frame("contend");
    wr(REG_CMD, 32'h5);
    wr(REG_CMD, 32'h0);
    frame("prefix off");
    rd(REG_STATUS, 32'h4, "prefix refused");
    wr(REG_CTRL, 32'h1);
    wr(REG_CMD, 32'h0);
    exp_q = {9'h0A5, 9'h0C3, 9'h01E, 9'h02F};
    frame("prefix");
    rd(REG_STATUS, 32'h0, "status clear");
    wr(REG_TS, 32'h00000ABC);
    rd(REG_TS, 32'h00000ABC, "pid");
    wr(REG_COMP, 32'h00000989);
    wr(REG_MEM_ADDR, 32'h0);
    wr(REG_MEM_DATA, 32'h5A);
    wr(REG_MEM_DATA, 32'hC6);
    for (int p = 0; p < 2; p++)
    begin
      wr(REG_CTRL, p ? 32'hA : 32'h2);
      wr(REG_CMD, 32'h3);
      exp_q = {9'h047, p ? 9'h04A : 9'h00A, 9'h0BC, p ? 9'h031 : 9'h020,
               9'h006, 9'h002, 9'h004, 9'h082, 9'h086, 9'h05A, 9'h0C6};
      frame("af");
    end
    wr(REG_CTRL, 32'h4);
    wr(REG_LABEL, 32'h12345670);
    wr(REG_MEM_ADDR, 32'h0);
    wr(REG_MEM_DATA, 32'h0);
    wr(REG_MEM_DATA, 32'h0);
    wr(REG_MSG_LEN, 32'h2);
    wr(REG_CMD, 32'h4);
    frame("empty element");
    rd(REG_STATUS, 32'h2, "element error");
    wr(REG_MEM_ADDR, 32'h0);
    wr(REG_MEM_DATA, 32'h0);
    wr(REG_MEM_DATA, 32'h2);
    wr(REG_MEM_DATA, 32'h11);
    wr(REG_MEM_DATA, 32'h22);
    wr(REG_MSG_LEN, 32'h4);
    wr(REG_CMD, 32'h4);
    // Header check byte: CRC8 of 1234567A with coset applied
    exp_q = {9'h012, 9'h034, 9'h056, 9'h07A, 9'h047, 9'h000, 9'h002,
             9'h011, 9'h022};
    repeat (39) exp_q.push_back(9'h000);
    exp_q = {exp_q, 9'h004, 9'h100, 9'h100, 9'h100, 9'h100};
    frame("cell");
    end_sim();
  end
endmodule
`default_nettype wire
